// file: verilog/spi_nv_command_status_unit.sv
// Purpose: serial command decoder and status register
// Assumes: serial clock far slower than mclk_in (8 or more cycles)
// Notes:   array, save and restore engines sit outside this block
`timescale 1ns/1ns
module spi_nv_command_status_unit (
  input  wire logic                mclk_in,
  input  wire logic                rst_b_in,
  input  wire logic                sck_in,
  input  wire logic                cs_b_in,
  input  wire logic                si_in,
  input  wire logic                write_guard_b_in,
  input  wire logic                nv_busy_in,
  output logic                     so_out,
  output logic                     so_oe_out,
  output spi_nv_pkg::status_t      status_out,
  output logic [1:0]               guard_level_out,
  output logic                     write_guard_active_out,
  output logic                     save_req_out,
  output logic                     restore_req_out,
  output logic                     array_read_start_out,
  output logic                     array_write_start_out,
  output logic                     autosave_en_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_SWDATA, ST_SREAD, ST_HOLD, ST_IGNORE
  } state_t;

  spi_nv_pkg::spi_pins_t pins_raw;
  spi_nv_pkg::spi_pins_t pins;
  spi_nv_pkg::status_t   status_reg;
  spi_nv_pkg::cmd_t      op_reg;
  spi_nv_pkg::cmd_t      cmd_dec;
  state_t                state_reg;
  logic                  sck_prev_reg;
  logic                  cs_prev_reg;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  cs_fall;
  logic                  cs_rise;
  logic [2:0]            bit_cnt_reg;
  logic [7:0]            rx_reg;
  logic [7:0]            rx_next;
  logic                  byte_done;
  logic                  accept;
  logic                  refuse;
  logic                  swr_byte;
  logic                  swr_apply;
  logic                  commit;
  logic                  pin_block_reg;
  logic [2:0]            tx_cnt_reg;
  logic [7:0]            tx_sh_reg;
  logic                  autosave_reg;

  assign pins_raw.sck     = sck_in;
  assign pins_raw.cs_b    = cs_b_in;
  assign pins_raw.si      = si_in;
  assign pins_raw.guard_b = write_guard_b_in;

  pin_sync #(
    .WIDTH   (4),
    .RST_VAL (spi_nv_pkg::PINS_RST)
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // edge finders on the synchronised pins
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_prev_reg <= 1'h0;
      cs_prev_reg  <= 1'h1;
    end else begin
      sck_prev_reg <= pins.sck;
      cs_prev_reg  <= pins.cs_b;
    end
  end

  assign sck_rise = pins.sck & ~sck_prev_reg;
  assign sck_fall = ~pins.sck & sck_prev_reg;
  // selection only starts on a falling edge, never on a held low level
  assign cs_fall  = ~pins.cs_b & cs_prev_reg; // R1
  assign cs_rise  = pins.cs_b & ~cs_prev_reg;

  assign rx_next   = {rx_reg[6:0], pins.si}; // R1
  assign byte_done = sck_rise && (bit_cnt_reg == spi_nv_pkg::LAST_BIT) &&
                     ((state_reg == ST_OPCODE) ||
                      (state_reg == ST_SWDATA));
  assign cmd_dec   = spi_nv_pkg::decode(rx_next); // R6 R22
  assign accept    = byte_done && (state_reg == ST_OPCODE) &&
                     (cmd_dec != spi_nv_pkg::CMD_NONE) &&
                     (!spi_nv_pkg::needs_latch(cmd_dec) ||
                      status_reg.latch);
  assign refuse    = byte_done && (state_reg == ST_OPCODE) && !accept;
  assign swr_byte  = byte_done && (state_reg == ST_SWDATA); // R12
  assign swr_apply = swr_byte && !pin_block_reg; // R21
  assign commit    = cs_rise && (state_reg == ST_HOLD);

  // serial input shifter, sampled on rising serial clock
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_reg <= spi_nv_pkg::FIRST_BIT;
      rx_reg      <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= spi_nv_pkg::FIRST_BIT;
    end else if (sck_rise && (state_reg != ST_IDLE)) begin // R19
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= rx_next;
    end
  end

  // command sequencer
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_IDLE;
      op_reg    <= spi_nv_pkg::CMD_NONE;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall) begin
      state_reg <= ST_OPCODE;
      op_reg    <= spi_nv_pkg::CMD_NONE;
    end else if (refuse) begin
      state_reg <= ST_IGNORE; // R18 R22
    end else if (accept) begin
      op_reg <= cmd_dec;
      unique case (cmd_dec)
        spi_nv_pkg::CMD_SWRITE: state_reg <= ST_SWDATA; // R3
        spi_nv_pkg::CMD_SREAD:  state_reg <= ST_SREAD; // R3 R15
        default:                state_reg <= ST_HOLD;
      endcase
    end else if (swr_byte) begin
      state_reg <= ST_HOLD;
    end
  end

  // pin guard is judged once at selection; later pin moves are ignored
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_block_reg <= 1'h0;
    end else if (cs_fall) begin
      pin_block_reg <= ~pins.guard_b & status_reg.pen; // R14 R21
    end
  end

  // status register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_reg <= spi_nv_pkg::STATUS_RST; // R9 R11 R17
    end else begin
      status_reg.busy <= nv_busy_in; // R8
      if (swr_apply) begin
        status_reg.pen   <= rx_next[7]; // R10 R16
        status_reg.spare <= rx_next[6:4]; // R11
        status_reg.level <= rx_next[3:2]; // R13
      end
      if (commit) begin
        if (op_reg == spi_nv_pkg::CMD_LSET) begin
          status_reg.latch <= 1'h1; // R2
        end else if (op_reg == spi_nv_pkg::CMD_LCLR) begin
          status_reg.latch <= 1'h0; // R2
        end else if (spi_nv_pkg::needs_latch(op_reg)) begin
          status_reg.latch <= 1'h0; // R20
        end
      end
    end
  end

  // requests to the outside engines
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      save_req_out          <= 1'h0;
      restore_req_out       <= 1'h0;
      array_read_start_out  <= 1'h0;
      array_write_start_out <= 1'h0;
    end else begin
      save_req_out    <= commit && (op_reg == spi_nv_pkg::CMD_SAVE); // R5 R16
      restore_req_out <= commit &&
                         (op_reg == spi_nv_pkg::CMD_RESTORE); // R5
      array_read_start_out  <= accept &&
                               (cmd_dec == spi_nv_pkg::CMD_AREAD); // R4
      array_write_start_out <= accept &&
                               (cmd_dec == spi_nv_pkg::CMD_AWRITE); // R4
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      autosave_reg <= spi_nv_pkg::AUTOSAVE_RST;
    end else if (commit && (op_reg == spi_nv_pkg::CMD_AS_ON)) begin
      autosave_reg <= 1'h1; // R6
    end else if (commit && (op_reg == spi_nv_pkg::CMD_AS_OFF)) begin
      autosave_reg <= 1'h0; // R6
    end
  end

  // status shifter, changes on falling serial clock, repeats every byte
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_cnt_reg <= spi_nv_pkg::FIRST_BIT;
      tx_sh_reg  <= 8'h00;
      so_out     <= 1'h0;
    end else if (cs_fall) begin
      tx_cnt_reg <= spi_nv_pkg::FIRST_BIT;
    end else if ((state_reg == ST_SREAD) && sck_fall) begin // R19
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == spi_nv_pkg::FIRST_BIT) begin
        so_out    <= status_reg[7]; // R15 R1
        tx_sh_reg <= {status_reg[6:0], 1'h0};
      end else begin
        so_out    <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'h0};
      end
    end
  end

  assign so_oe_out              = (state_reg == ST_SREAD); // R18
  assign status_out             = status_reg; // R7
  assign guard_level_out        = status_reg.level; // R13
  assign write_guard_active_out = status_reg.pen & ~pins.guard_b; // R14
  assign autosave_en_out        = autosave_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_commit;
    cs_rise && (state_reg == ST_HOLD);
  endsequence

  sequence s_opcode_byte;
    byte_done && (state_reg == ST_OPCODE);
  endsequence

  sequence s_byte_start;
    (state_reg == ST_SREAD) && sck_fall &&
      (tx_cnt_reg == spi_nv_pkg::FIRST_BIT);
  endsequence

  property p_ignore_quiet;
    (state_reg == ST_IGNORE) && !cs_rise |=>
      (state_reg == ST_IGNORE) && !so_oe_out;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) // R18
    else $error("serial out driven while ignoring");

  property p_unknown_ignored;
    s_opcode_byte ##0 (cmd_dec == spi_nv_pkg::CMD_NONE) |=>
      (state_reg == ST_IGNORE);
  endproperty
  a_unknown_ignored: assert property (p_unknown_ignored) // R22
    else $error("unknown opcode not ignored");

  property p_latch_gate;
    s_opcode_byte ##0 (spi_nv_pkg::needs_latch(cmd_dec) &&
      !status_reg.latch) |=> (state_reg == ST_IGNORE);
  endproperty
  a_latch_gate: assert property (p_latch_gate) // R9
    else $error("write command taken without latch");

  property p_latch_set;
    s_commit ##0 (op_reg == spi_nv_pkg::CMD_LSET) |=> status_reg.latch;
  endproperty
  a_latch_set: assert property (p_latch_set) // R2
    else $error("latch not set");

  property p_latch_clear;
    s_commit ##0 spi_nv_pkg::needs_latch(op_reg) |=> !status_reg.latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) // R20
    else $error("latch not cleared after write command");

  property p_busy_follow;
    nv_busy_in |=> status_reg.busy;
  endproperty
  a_busy_follow: assert property (p_busy_follow) // R8
    else $error("busy flag does not follow engine");

  property p_swr_keeps_latch;
    swr_byte |=> (status_reg.latch == $past(status_reg.latch));
  endproperty
  a_swr_keeps_latch: assert property (p_swr_keeps_latch) // R10
    else $error("status write altered latch");

  property p_guard_reject;
    (swr_byte && pin_block_reg) |=> $stable(status_reg[7:2]);
  endproperty
  a_guard_reject: assert property (p_guard_reject) // R21
    else $error("status write not rejected by guard pin");

  property p_so_on_fall;
    $changed(so_out) |-> $past(sck_fall) && $past(state_reg == ST_SREAD);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) // R19
    else $error("serial out changed off a falling edge");

  property p_save_once;
    save_req_out |-> !status_reg.latch ##1 !save_req_out;
  endproperty
  a_save_once: assert property (p_save_once) // R5
    else $error("save request malformed");

  property p_latch_clr_cmd;
    s_commit ##0 (op_reg == spi_nv_pkg::CMD_LCLR) |=> !status_reg.latch;
  endproperty
  a_latch_clr_cmd: assert property (p_latch_clr_cmd) // R2
    else $error("latch not cleared by clear command");

  property p_save_go;
    s_commit ##0 (op_reg == spi_nv_pkg::CMD_SAVE) |=> save_req_out;
  endproperty
  a_save_go: assert property (p_save_go) // R5
    else $error("save request missing");

  property p_restore_go;
    s_commit ##0 (op_reg == spi_nv_pkg::CMD_RESTORE) |=> restore_req_out;
  endproperty
  a_restore_go: assert property (p_restore_go) // R5
    else $error("restore request missing");

  property p_tx_load;
    s_byte_start |=> (so_out == $past(status_reg[7]));
  endproperty
  a_tx_load: assert property (p_tx_load) // R15
    else $error("status byte not loaded at byte start");

  property p_swr_fields;
    swr_apply |=> (status_reg[7:2] == $past(rx_next[7:2]));
  endproperty
  a_swr_fields: assert property (p_swr_fields) // R10 R11 R13
    else $error("status write stored wrong bits");

  property p_busy_drop;
    !nv_busy_in |=> !status_reg.busy;
  endproperty
  a_busy_drop: assert property (p_busy_drop) // R8
    else $error("busy flag stuck");

  property p_awrite_gate;
    array_write_start_out |-> $past(status_reg.latch);
  endproperty
  a_awrite_gate: assert property (p_awrite_gate) // R4 R9
    else $error("array write started without latch");

  property p_autosave_gate;
    $changed(autosave_en_out) |-> $past(commit) && !status_reg.latch;
  endproperty
  a_autosave_gate: assert property (p_autosave_gate) // R6 R20
    else $error("autosave changed outside a committed command");

endmodule

// file: verilog/spi_nv_pkg.sv
// Purpose: constants, types and decode for the serial command unit
// Assumes: opcodes arrive whole, most significant bit first
// Notes:   status fields sit at the bit positions given below
//
// What this block does
// R1 - bytes shift in MSB first; each command begins at chip select fall.
// R2 - opcode 06 sets the write latch; opcode 04 clears it.
// R3 - opcode 05 starts status read; opcode 01 starts status write.
// R4 - opcode 03 starts array read; opcode 02 starts array write.
// R5 - opcode 3C requests a save; opcode 60 requests a restore.
// R6 - ten opcodes known; 59 enables autosave, 19 disables; 1E reserved.
// R7 - status: busy, latch, two guard level bits, three spare, pin guard.
// R8 - busy is read-only and shows save or restore in progress.
// R9 - write latch is zero after power-up; one means writes enabled.
// R10 - status write never alters busy or write latch.
// R11 - spare bits 4 to 6 are writable, volatile, zero at power-up.
// R12 - master sets latch, sends status write opcode, then eight bits.
// R13 - two guard level bits select one of four protection levels.
// R14 - guard pin acts only while pin guard enable is one.
// R15 - after status read opcode the status shifts out on serial out.
// R16 - status becomes nonvolatile only through a later save.
// R17 - latch, guard bits, spare bits and pin guard start at zero.
// R18 - unknown opcode: ignore rest of selection, serial out stays off.
// R19 - sample input on rising clock, change output on falling clock.
// R20 - latch clears after status write, array write, save, restore, autosave.
// R21 - guard pin low with pin guard set rejects every status write.
// R22 - reserved opcode is handled as an unknown opcode.
package spi_nv_pkg;

  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_ARR_RD    = 8'h03;
  localparam logic [7:0] OP_ARR_WR    = 8'h02;
  localparam logic [7:0] OP_SAVE      = 8'h3C;
  localparam logic [7:0] OP_RESTORE   = 8'h60;
  localparam logic [7:0] OP_AS_ON     = 8'h59;
  localparam logic [7:0] OP_AS_OFF    = 8'h19;

  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] FIRST_BIT    = 3'h0;
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic       AUTOSAVE_RST = 1'h1;
  localparam logic [3:0] PINS_RST     = 4'h5;

  // bit 7 pin guard, 6..4 spare, 3..2 guard level, 1 latch, 0 busy
  typedef struct packed {
    logic       pen;
    logic [2:0] spare;
    logic [1:0] level;
    logic       latch;
    logic       busy;
  } status_t;

  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
    logic guard_b;
  } spi_pins_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_LSET, CMD_LCLR, CMD_SREAD, CMD_SWRITE, CMD_AREAD,
    CMD_AWRITE, CMD_SAVE, CMD_RESTORE, CMD_AS_ON, CMD_AS_OFF
  } cmd_t;

  function automatic cmd_t decode(input logic [7:0] op);
    cmd_t c;
    c = CMD_NONE;
    unique case (op)
      OP_LATCH_SET: c = CMD_LSET;
      OP_LATCH_CLR: c = CMD_LCLR;
      OP_STAT_RD:   c = CMD_SREAD;
      OP_STAT_WR:   c = CMD_SWRITE;
      OP_ARR_RD:    c = CMD_AREAD;
      OP_ARR_WR:    c = CMD_AWRITE;
      OP_SAVE:      c = CMD_SAVE;
      OP_RESTORE:   c = CMD_RESTORE;
      OP_AS_ON:     c = CMD_AS_ON;
      OP_AS_OFF:    c = CMD_AS_OFF;
      default:      c = CMD_NONE;
    endcase
    return c;
  endfunction

  function automatic logic needs_latch(input cmd_t c);
    return (c == CMD_SWRITE) || (c == CMD_AWRITE) || (c == CMD_SAVE) ||
           (c == CMD_RESTORE) || (c == CMD_AS_ON) || (c == CMD_AS_OFF);
  endfunction

endpackage

// file: verilog/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are levels from outside the clock domain
// Notes:   only the second stage is visible to other logic
`timescale 1ns/1ns
module pin_sync #(
  parameter int         WIDTH   = 4,
  parameter logic [3:0] RST_VAL = 4'h0
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= RST_VAL[WIDTH-1:0];
      sync_out <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: verification/spi_master_model.sv
// Purpose: serial bus master driving the command unit, mode 0 or 3
// Assumes: serial period 400 ns, eight mclk cycles
// Notes:   pins change on falling mclk; data in taken before each rise
`timescale 1ns/1ns
module spi_master_model (
  input  wire logic mclk_in,
  input  wire logic so_in,
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      si_out
);
  // half of the serial period in mclk cycles
  localparam int HALF = 4;
  // serial clock level between frames: low in mode 0, high in mode 3
  logic idle_hi;

  initial begin
    sck_out  = 1'b0;
    cs_b_out = 1'b1;
    si_out   = 1'b0;
    idle_hi  = 1'b0;
  end

  task automatic set_mode(input logic hi);
    idle_hi = hi;
    sck_out = hi;
    wait_clk(2 * HALF);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic begin_sel();
    cs_b_out = 1'b0;
    wait_clk(HALF);
  endtask

  task automatic end_sel();
    wait_clk(HALF);
    cs_b_out = 1'b1;
    // a released data line must not keep the last bit
    si_out = ~si_out;
    wait_clk(2 * HALF);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      if (sck_out) sck_out = 1'b0;
      wait_clk(HALF);
      rx[i] = so_in;
      sck_out = 1'b1;
      wait_clk(HALF);
    end
    // mode 3 leaves the clock high after the last rise
    if (!idle_hi) sck_out = 1'b0;
  endtask
endmodule

// file: verification/spi_nv_command_status_unit_tb.sv
// Purpose: self-checking bench for the serial command and status unit
// Assumes: master model drives the serial pins at falling mclk
// Notes:   one-cycle request pulses are counted, not sampled
`timescale 1ns/1ns
module spi_nv_command_status_unit_tb;
  logic                mclk_in, rst_b_in, sck, cs_b, si, guard_b, busy_in;
  logic                so, so_oe, so_last, act, sv_p, rs_p, ar_p, aw_p, as;
  wire logic           so_line;
  logic [1:0]          lvl;
  spi_nv_pkg::status_t st;
  int                  n_mismatch, total_checks, n_sv, n_rs, n_ar, n_aw, n_oe;

  spi_nv_command_status_unit DUT (
    .mclk_in                (mclk_in),
    .rst_b_in               (rst_b_in),
    .sck_in                 (sck),
    .cs_b_in                (cs_b),
    .si_in                  (si),
    .write_guard_b_in       (guard_b),
    .nv_busy_in             (busy_in),
    .so_out                 (so),
    .so_oe_out              (so_oe),
    .status_out             (st),
    .guard_level_out        (lvl),
    .write_guard_active_out (act),
    .save_req_out           (sv_p),
    .restore_req_out        (rs_p),
    .array_read_start_out   (ar_p),
    .array_write_start_out  (aw_p),
    .autosave_en_out        (as)
  );
  spi_master_model mst (
    .mclk_in  (mclk_in),
    .so_in    (so_line),
    .sck_out  (sck),
    .cs_b_out (cs_b),
    .si_out   (si)
  );

  // undriven serial out shows the inverse of its last driven bit
  assign so_line = so_oe ? so : ~so_last;
  always @(posedge mclk_in) begin
    if (so_oe === 1'b1) so_last <= so;
    n_sv <= n_sv + int'(sv_p === 1'b1);
    n_rs <= n_rs + int'(rs_p === 1'b1);
    n_ar <= n_ar + int'(ar_p === 1'b1);
    n_aw <= n_aw + int'(aw_p === 1'b1);
    n_oe <= n_oe + int'(so_oe !== 1'b0);
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] b2 = 8'h00,
                     input bit two = 1'b0);
    logic [7:0] rx;
    mst.begin_sel();
    mst.xfer(op, rx);
    if (two) mst.xfer(b2, rx);
    mst.end_sel();
  endtask

  task automatic rd(input logic [7:0] exp, input string what);
    logic [7:0] rx;
    logic [7:0] v;
    mst.begin_sel();
    mst.xfer(8'h05, rx);
    mst.xfer(8'h00, v);
    mst.end_sel();
    check(what, v, exp);
  endtask

  task automatic t_reset();
    check("status", st, 8'h00);
    check("autosave", 8'(as), 8'h01);
    check("so_oe", 8'(so_oe), 8'h00);
    rd(8'h00, "read reset");
    $display("done reset");
  endtask

  task automatic t_latch();
    cmd(8'h06);
    rd(8'h02, "read latch set");
    cmd(8'h04);
    rd(8'h00, "read latch clear");
    $display("done latch");
  endtask

  task automatic t_stwrite();
    cmd(8'h01, 8'hFF, 1'b1);
    check("no latch write", st, 8'h00);
    cmd(8'h06);
    cmd(8'h01, 8'hFF, 1'b1);
    check("write ff", st, 8'hFC);
    check("level", 8'(lvl), 8'h03);
    rd(8'hFC, "read ff");
    $display("done status write");
  endtask

  task automatic t_guard();
    guard_b = 1'b0;
    mst.wait_clk(4);
    check("guard act", 8'(act), 8'h01);
    cmd(8'h06);
    cmd(8'h01, 8'h00, 1'b1);
    check("guarded write", st, 8'hFC);
    guard_b = 1'b1;
    cmd(8'h06);
    cmd(8'h01, 8'h0C, 1'b1);
    check("open write", st, 8'h0C);
    guard_b = 1'b0;
    mst.wait_clk(4);
    check("guard idle", 8'(act), 8'h00);
    cmd(8'h06);
    cmd(8'h01, 8'h00, 1'b1);
    check("pen off write", st, 8'h00);
    guard_b = 1'b1;
    $display("done guard");
  endtask

  task automatic t_nv();
    cmd(8'h3C);
    cmd(8'h60);
    check("saves refused", 8'(n_sv + n_rs), 8'h00);
    cmd(8'h06);
    cmd(8'h3C);
    check("save", 8'(n_sv), 8'h01);
    check("latch after save", st, 8'h00);
    cmd(8'h06);
    cmd(8'h60);
    check("restore", 8'(n_rs), 8'h01);
    check("latch after restore", st, 8'h00);
    cmd(8'h06);
    cmd(8'h19);
    check("autosave off", 8'(as), 8'h00);
    cmd(8'h59);
    check("autosave refused", 8'(as), 8'h00);
    cmd(8'h06);
    cmd(8'h59);
    check("autosave on", 8'(as), 8'h01);
    check("latch after autosave", st, 8'h00);
    $display("done nv");
  endtask

  task automatic t_array();
    cmd(8'h03);
    cmd(8'h02);
    check("array read", 8'(n_ar), 8'h01);
    check("array write refused", 8'(n_aw), 8'h00);
    cmd(8'h06);
    cmd(8'h02);
    check("array write", 8'(n_aw), 8'h01);
    check("latch after write", st, 8'h00);
    $display("done array");
  endtask

  task automatic t_bad();
    logic [7:0] ops [2];
    int base;
    ops = '{8'h1E, 8'hFF};
    base = n_oe;
    foreach (ops[i]) begin
      cmd(ops[i], 8'h06, 1'b1);
      check("ignored tail", st, 8'h00);
    end
    check("so off", 8'(n_oe - base), 8'h00);
    $display("done bad opcode");
  endtask

  task automatic t_busy();
    busy_in = 1'b1;
    mst.wait_clk(3);
    check("busy bit", st, 8'h01);
    rd(8'h01, "read busy");
    busy_in = 1'b0;
    mst.wait_clk(3);
    check("busy gone", st, 8'h00);
    $display("done busy");
  endtask

  task automatic t_mode3();
    mst.set_mode(1'b1);
    cmd(8'h06);
    rd(8'h02, "mode 3 latch");
    cmd(8'h01, 8'h7C, 1'b1);
    rd(8'h7C, "mode 3 write");
    mst.set_mode(1'b0);
    $display("done mode 3");
  endtask

  task automatic t_rerun();
    cmd(8'h06);
    check("latch before reset", st, 8'h7E);
    rst_b_in = 1'b0;
    mst.wait_clk(2);
    check("status in reset", st, 8'h00);
    check("autosave in reset", 8'(as), 8'h01);
    rst_b_in = 1'b1;
    mst.wait_clk(3);
    rd(8'h00, "read after reset");
    $display("done second reset");
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  initial begin
    rst_b_in = 1'b0;
    guard_b  = 1'b1;
    busy_in  = 1'b0;
    so_last  = 1'b0;
    repeat (3) @(negedge mclk_in);
    rst_b_in = 1'b1;
    mst.wait_clk(3);
    t_reset();
    t_latch();
    t_stwrite();
    t_guard();
    t_nv();
    t_array();
    t_bad();
    t_busy();
    t_mode3();
    t_rerun();
    final_report();
  end

  initial begin
    repeat (90000) @(posedge mclk_in);
    n_mismatch++;
    final_report();
  end
endmodule
